/* File: hdl/switch_port_traffic_control.sv */
// Port traffic admission, back pressure and storm control with its FIFO.
`timescale 1ns/1ps

module tc_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Fill side.
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side.
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_s;
  fifo_s st_ff;
  fifo_s nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (st_ff.cnt != FULL_CNT);
  assign out_valid = (st_ff.cnt != '0);
  assign out_data = mem[st_ff.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wr = st_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd = st_ff.rd + 1'b1;
    end
    unique case ({push, pop})
      2'b10: nxt_st.cnt = st_ff.cnt + 1'b1;
      2'b01: nxt_st.cnt = st_ff.cnt - 1'b1;
      default: nxt_st.cnt = st_ff.cnt;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Memory words hold no control state and need no reset.
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[st_ff.wr] <= in_data;
    end
  end
endmodule : tc_fifo

module switch_port_traffic_control #(
  parameter logic [31:0] IV100_CYCLES = 32'(tc_pkg::IV100_CYC),
  parameter logic [31:0] IV10_CYCLES = 32'(tc_pkg::IV10_CYC),
  parameter logic [31:0] CARRIER_CYCLES = 32'(tc_pkg::CARRIER_CYC)
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB register slave.
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port identity.
  input wire logic [2:0] port_id,
  // Receive stream from the MAC.
  input wire logic rx_valid,
  input wire tc_pkg::rx_beat_s rx_beat,
  output logic rx_ready,
  // Forwarded stream to the fabric.
  output logic fab_valid,
  output tc_pkg::fab_beat_s fab_beat,
  input wire logic fab_ready,
  // Fabric resources and flow control.
  input wire logic res_busy,
  output logic rx_pause,
  output logic xoff_req,
  output logic xon_req,
  // Transmit side of the port.
  input wire logic tx_q_nempty,
  input wire logic tx_col,
  input wire logic tx_done,
  output logic crs_preamble,
  output logic tx_grant,
  output logic skip_backoff,
  output logic aggr_backoff,
  output logic xcol_drop
);
  import tc_pkg::*;

  typedef struct packed {
    logic aggr;
    logic nxdrop;
    logic bp_en;
    logic mc_inc;
    logic storm_en;
    logic spd100;
    logic fdx;
    logic [7:0] thr;
    logic in_frame;
    logic drop_cur;
    logic fc_on;
    bp_e bp;
    logic [15:0] bp_cnt;
    logic [4:0] col_cnt;
    logic [31:0] iv_cnt;
    logic [7:0] storm_cnt;
    logic [15:0] drop_cnt;
    logic [31:0] rdata;
    logic rerr;
    logic xoff;
    logic xon;
    logic pause_p;
    logic xcol;
  } tc_s;

  tc_s st_ff;
  tc_s nxt_st;
  logic sop;
  logic err_frame;
  logic local_frame;
  logic counted;
  logic storm_drop;
  logic sop_drop;
  logic drop_now;
  logic f_in_ready;
  logic f_in_valid;
  logic f_out_valid;
  logic [FAB_W-1:0] f_out_data;
  logic bp_req;
  logic iv_end;
  logic [31:0] iv_len;

  function automatic logic reg_hit(input logic [11:0] a, input logic [7:0] idx);
    reg_hit = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
  endfunction : reg_hit

  // Error frame check.
  // error frame detect
  assign err_frame = rx_beat.frame_err | rx_beat.fcs_err | rx_beat.align_err | rx_beat.len_err;
  assign local_frame = (rx_beat.dst_port == port_id);
  assign counted = rx_beat.bcast | (st_ff.mc_inc & rx_beat.mcast);
  assign storm_drop = st_ff.storm_en & counted & (st_ff.storm_cnt >= st_ff.thr);
  assign sop_drop = err_frame | rx_beat.pause | local_frame | storm_drop;
  assign sop = rx_valid & ~st_ff.in_frame;
  assign drop_now = st_ff.in_frame ? st_ff.drop_cur : sop_drop;
  assign f_in_valid = rx_valid & ~drop_now;
  assign rx_ready = drop_now | f_in_ready;

  assign bp_req = st_ff.fc_on & st_ff.bp_en & ~st_ff.fdx;
  assign iv_len = st_ff.spd100 ? IV100_CYCLES : IV10_CYCLES;
  assign iv_end = (st_ff.iv_cnt >= iv_len - 32'h00000001);

  tc_fifo #(
    .WIDTH(FAB_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(f_in_valid),
    .in_data({rx_beat.data, rx_beat.last}),
    .in_ready(f_in_ready),
    .out_valid(f_out_valid),
    .out_data(f_out_data),
    .out_ready(fab_ready)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.xoff = 1'b0;
    nxt_st.xon = 1'b0;
    nxt_st.pause_p = 1'b0;
    nxt_st.xcol = 1'b0;

    // APB read data and error are captured in the setup phase.
    if (psel && !penable) begin
      nxt_st.rerr = 1'b0;
      nxt_st.rdata = 32'h00000000;
      if (reg_hit(paddr, IDX_CFG3)) begin
        nxt_st.rdata[AGGR_BIT] = st_ff.aggr;
      end else if (reg_hit(paddr, IDX_CFG4)) begin
        nxt_st.rdata[NXDROP_BIT] = st_ff.nxdrop;
        nxt_st.rdata[BP_BIT] = st_ff.bp_en;
      end else if (reg_hit(paddr, IDX_STORM)) begin
        nxt_st.rdata[7:0] = st_ff.thr;
        nxt_st.rdata[MC_INC_BIT] = st_ff.mc_inc;
      end else if (reg_hit(paddr, IDX_PORT)) begin
        nxt_st.rdata[STORM_EN_BIT] = st_ff.storm_en;
        nxt_st.rdata[SPD100_BIT] = st_ff.spd100;
        nxt_st.rdata[FDX_BIT] = st_ff.fdx;
      end else if (reg_hit(paddr, IDX_STAT)) begin
        nxt_st.rdata[ST_BP_BIT] = (st_ff.bp == BP_CARRIER) | (st_ff.bp == BP_GAP);
        nxt_st.rdata[ST_FC_BIT] = st_ff.fc_on;
        nxt_st.rdata[ST_CNT_LSB +: 8] = st_ff.storm_cnt;
      end else if (reg_hit(paddr, IDX_DROPS)) begin
        nxt_st.rdata[15:0] = st_ff.drop_cnt;
      end else begin
        nxt_st.rerr = 1'b1;
      end
    end

    // Writes take effect at the access-phase edge.
    if (psel && penable && pwrite) begin
      if (reg_hit(paddr, IDX_CFG3)) begin
        nxt_st.aggr = pwdata[AGGR_BIT];
      end
      if (reg_hit(paddr, IDX_CFG4)) begin
        nxt_st.nxdrop = pwdata[NXDROP_BIT];
        nxt_st.bp_en = pwdata[BP_BIT];
      end
      if (reg_hit(paddr, IDX_STORM)) begin
        nxt_st.thr = pwdata[7:0];
        nxt_st.mc_inc = pwdata[MC_INC_BIT];
      end
      if (reg_hit(paddr, IDX_PORT)) begin
        nxt_st.storm_en = pwdata[STORM_EN_BIT];
        nxt_st.spd100 = pwdata[SPD100_BIT];
        nxt_st.fdx = pwdata[FDX_BIT];
      end
    end

    // Frame tracking; the drop decision at the first beat holds to the last.
    if (rx_valid && rx_ready) begin
      nxt_st.in_frame = ~rx_beat.last;
      if (sop) begin
        nxt_st.drop_cur = sop_drop;
        if (sop_drop) begin
          nxt_st.drop_cnt = st_ff.drop_cnt + 16'h0001;
        end
        nxt_st.pause_p = rx_beat.pause & ~err_frame;
      end
    end

    if (rx_valid && rx_ready && sop && !sop_drop && res_busy) begin
      nxt_st.fc_on = 1'b1;
      nxt_st.xoff = st_ff.fdx & ~st_ff.fc_on;
    end else if (st_ff.fc_on && !res_busy) begin
      nxt_st.fc_on = 1'b0;
      nxt_st.xon = st_ff.fdx;
    end

    if (iv_end) begin
      nxt_st.iv_cnt = 32'h00000000;
      nxt_st.storm_cnt = 8'h00;
    end else begin
      nxt_st.iv_cnt = st_ff.iv_cnt + 32'h00000001;
    end
    // A frame counted in the clearing cycle belongs to the new interval.
    if (rx_valid && rx_ready && sop && counted) begin
      if (iv_end) begin
        nxt_st.storm_cnt = 8'h01;
      end else if (st_ff.storm_cnt != 8'hFF) begin
        nxt_st.storm_cnt = st_ff.storm_cnt + 8'h01;
      end
    end

    // Carrier-sense back pressure sequencer.
    unique case (st_ff.bp)
      BP_OFF: begin
        nxt_st.bp_cnt = 16'h0000;
        if (bp_req) begin
          nxt_st.bp = tx_q_nempty ? BP_TX : BP_CARRIER;
        end
      end
      BP_CARRIER: begin
        if (!bp_req) begin
          nxt_st.bp = BP_OFF;
        end else if (tx_q_nempty) begin
          nxt_st.bp = BP_TX;
        end else if (tx_col) begin
          nxt_st.bp_cnt = 16'h0000;
        end else if ({16'h0000, st_ff.bp_cnt} >= CARRIER_CYCLES - 32'h00000001) begin
          nxt_st.bp = BP_GAP;
          nxt_st.bp_cnt = 16'h0000;
        end else begin
          nxt_st.bp_cnt = st_ff.bp_cnt + 16'h0001;
        end
      end
      BP_GAP: begin
        if (!bp_req) begin
          nxt_st.bp = BP_OFF;
        end else if (tx_q_nempty) begin
          nxt_st.bp = BP_TX;
        end else if (tx_col || (st_ff.bp_cnt >= GAP_CYC - 16'h0001)) begin
          nxt_st.bp = BP_CARRIER;
          nxt_st.bp_cnt = 16'h0000;
        end else begin
          nxt_st.bp_cnt = st_ff.bp_cnt + 16'h0001;
        end
      end
      BP_TX: begin
        nxt_st.bp_cnt = 16'h0000;
        if (!tx_q_nempty) begin
          nxt_st.bp = bp_req ? BP_CARRIER : BP_OFF;
        end
      end
    endcase

    if (tx_done) begin
      nxt_st.col_cnt = 5'h00;
    end else if (tx_col && (st_ff.bp == BP_OFF || st_ff.bp == BP_TX)) begin
      if (st_ff.col_cnt + 5'h01 >= XCOL_LIMIT) begin
        nxt_st.col_cnt = 5'h00;
        nxt_st.xcol = ~st_ff.nxdrop;
      end else begin
        nxt_st.col_cnt = st_ff.col_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.aggr <= 1'b0;
      st_ff.nxdrop <= 1'b0;
      st_ff.bp_en <= 1'b0;
      st_ff.thr <= THR_RST;
      st_ff.spd100 <= SPD100_RST;
      st_ff.fdx <= FDX_RST;
      st_ff.bp <= BP_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign pready = psel & penable;
  assign pslverr = psel & penable & st_ff.rerr;
  assign fab_valid = f_out_valid;
  assign fab_beat = f_out_data;
  assign rx_pause = st_ff.pause_p;
  assign xoff_req = st_ff.xoff;
  assign xon_req = st_ff.xon;
  assign crs_preamble = (st_ff.bp == BP_CARRIER);
  assign tx_grant = (st_ff.bp == BP_OFF) | (st_ff.bp == BP_TX);
  assign skip_backoff = bp_req;
  assign aggr_backoff = st_ff.aggr;
  assign xcol_drop = st_ff.xcol;
endmodule : switch_port_traffic_control

/* File: hdl/tc_pkg.sv */
// Constants, register map, stream types and back pressure states of the port traffic controller.
package tc_pkg;
  localparam int CLK_MHZ = 200;
  localparam logic [7:0] IDX_CFG3 = 8'h03;
  localparam logic [7:0] IDX_CFG4 = 8'h04;
  localparam logic [7:0] IDX_STORM = 8'h06;
  localparam logic [7:0] IDX_PORT = 8'h08;
  localparam logic [7:0] IDX_STAT = 8'h09;
  localparam logic [7:0] IDX_DROPS = 8'h0A;
  localparam int AGGR_BIT = 0;
  localparam int NXDROP_BIT = 3;
  localparam int BP_BIT = 5;
  localparam int MC_INC_BIT = 8;
  localparam int STORM_EN_BIT = 0;
  localparam int SPD100_BIT = 1;
  localparam int FDX_BIT = 2;
  localparam int ST_BP_BIT = 0;
  localparam int ST_FC_BIT = 1;
  localparam int ST_CNT_LSB = 8;
  localparam logic [7:0] THR_RST = 8'h4A;
  localparam logic SPD100_RST = 1'b1;
  localparam logic FDX_RST = 1'b0;
  localparam int IV100_MS = 50;
  localparam int IV10_MS = 500;
  localparam int IV100_CYC = IV100_MS * CLK_MHZ * 1000;
  localparam int IV10_CYC = IV10_MS * CLK_MHZ * 1000;
  localparam int CARRIER_US = 50;
  localparam int CARRIER_CYC = CARRIER_US * CLK_MHZ;
  localparam int GAP_NS = 960;
  localparam int GAP_CYC_I = (GAP_NS * CLK_MHZ) / 1000;
  localparam logic [15:0] GAP_CYC = GAP_CYC_I[15:0];
  localparam logic [4:0] XCOL_LIMIT = 5'h10;
  localparam int FIFO_D = 16;
  typedef struct packed {
    logic [31:0] data;
    logic last;
    logic frame_err;
    logic fcs_err;
    logic align_err;
    logic len_err;
    logic pause;
    logic bcast;
    logic mcast;
    logic [2:0] dst_port;
  } rx_beat_s;
  typedef struct packed {
    logic [31:0] data;
    logic last;
  } fab_beat_s;
  localparam int FAB_W = $bits(fab_beat_s);
  typedef enum logic [1:0] {BP_OFF, BP_CARRIER, BP_GAP, BP_TX} bp_e;
endpackage : tc_pkg

/* File: tb/switch_port_traffic_control_bench.sv */
// Self-checking bench of the port traffic controller.
`timescale 1ns/1ps
module switch_port_traffic_control_bench;
  import tc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, last_fab;
  logic [2:0] port_id;
  logic rx_valid, rx_ready, fab_valid, fab_ready, res_busy, rx_pause, xoff_req, xon_req;
  logic tx_q_nempty, tx_col, tx_done, crs_preamble, tx_grant, skip_backoff, aggr_backoff;
  logic xcol_drop;
  rx_beat_s rx_beat, f;
  fab_beat_s fab_beat;
  int err_total, comparisons, cyc, n0, n_fab, n_xoff, n_xon, n_pause, n_xcol;
  switch_port_traffic_control #(.IV100_CYCLES(32'd400), .IV10_CYCLES(32'd2000),
    .CARRIER_CYCLES(32'd50)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_id(port_id), .rx_valid(rx_valid), .rx_beat(rx_beat), .rx_ready(rx_ready),
    .fab_valid(fab_valid), .fab_beat(fab_beat), .fab_ready(fab_ready), .res_busy(res_busy),
    .rx_pause(rx_pause), .xoff_req(xoff_req), .xon_req(xon_req), .tx_q_nempty(tx_q_nempty),
    .tx_col(tx_col), .tx_done(tx_done), .crs_preamble(crs_preamble), .tx_grant(tx_grant),
    .skip_backoff(skip_backoff), .aggr_backoff(aggr_backoff), .xcol_drop(xcol_drop)
  );
  tc_station st (.pclk(pclk), .rx_valid(rx_valid), .rx_beat(rx_beat), .rx_ready(rx_ready));
  always #2.5 pclk = ~pclk;
  always @(negedge pclk) begin
    if (fab_valid && fab_ready) begin
      n_fab++;
      last_fab = fab_beat.data;
    end
    n_xoff += xoff_req;
    n_xon += xon_req;
    n_pause += rx_pause;
    n_xcol += xcol_drop;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("mismatches %0d of %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic t_regs();
    apb(0, IDX_CFG3, 0);
    chk(q[AGGR_BIT] === 1'b0 && aggr_backoff === 1'b0, "aggressive backoff set");
    apb(0, IDX_CFG4, 0);
    chk(q[NXDROP_BIT] === 1'b0 && q[BP_BIT] === 1'b0, "cfg4 reset");
    apb(0, IDX_STORM, 0);
    chk(q[7:0] === THR_RST, "storm threshold reset");
    apb(0, IDX_PORT, 0);
    chk(q[2:0] === {FDX_RST, SPD100_RST, 1'b0}, "port reset");
    apb(1, IDX_CFG3, 32'h1);
    chk(aggr_backoff === 1'b1, "aggressive backoff not applied");
    apb(0, 8'hFF, 0);
    chk(last_err === 1'b1 && q === 32'h0, "unmapped access");
  endtask : t_regs
  task automatic t_filter();
    n0 = n_fab;
    f = '0;
    f.dst_port = 3'h2;
    f.data = 32'hA0;
    st.frame(f, 2);
    for (int k = 0; k < 6; k++) begin
      f = '0;
      f.dst_port = 3'h2;
      if (k < 5) f[9 - k] = 1'b1;
      else f.dst_port = port_id;
      st.frame(f, 3);
    end
    idle(4);
    chk(n_fab - n0 == 2 && last_fab === 32'hA1, "bad frame forwarded");
    chk(n_pause == 1, "pause not consumed");
    apb(0, IDX_DROPS, 0);
    chk(q[15:0] === 16'h0006, "drop count");
  endtask : t_filter
  task automatic t_fifo();
    fab_ready <= 1'b0;
    n0 = n_fab;
    f = '0;
    f.dst_port = 3'h2;
    f.data = 32'h100;
    fork
      st.frame(f, 20);
    join_none
    idle(30);
    chk(rx_ready === 1'b0 && fab_valid === 1'b1, "fifo never full");
    fab_ready <= 1'b1;
    idle(30);
    chk(n_fab - n0 == 20 && last_fab === 32'h113, "fifo drain");
  endtask : t_fifo
  task automatic t_flow();
    apb(1, IDX_PORT, 32'h6);
    res_busy <= 1'b1;
    st.frame(f, 1);
    idle(3);
    chk(n_xoff == 1 && n_xon == 0, "no xoff");
    res_busy <= 1'b0;
    idle(3);
    chk(n_xon == 1, "no xon");
  endtask : t_flow
  task automatic t_back();
    apb(1, IDX_PORT, 32'h2);
    apb(1, IDX_CFG4, 32'h20);
    res_busy <= 1'b1;
    st.frame(f, 1);
    idle(3);
    chk(crs_preamble === 1'b1 && skip_backoff === 1'b1, "no carrier");
    tx_col <= 1'b1;
    idle(1);
    tx_col <= 1'b0;
    idle(2);
    chk(crs_preamble === 1'b1, "carrier lost on collision");
    tx_q_nempty <= 1'b1;
    idle(3);
    chk(tx_grant === 1'b1 && crs_preamble === 1'b0, "queue not served");
    tx_q_nempty <= 1'b0;
    idle(3);
    chk(crs_preamble === 1'b1, "carrier not resumed");
    idle(260);
    apb(0, IDX_STAT, 0);
    chk(q[ST_FC_BIT] === 1'b1, "flow control lost");
    chk(q[ST_BP_BIT] === 1'b1, "back pressure status idle");
    res_busy <= 1'b0;
    idle(4);
    chk(crs_preamble === 1'b0 && tx_grant === 1'b1, "carrier after release");
  endtask : t_back
  task automatic t_xcol();
    for (int r = 0; r < 2; r++) begin
      apb(1, IDX_CFG4, r ? 32'h8 : 32'h0);
      n0 = n_xcol;
      repeat (16) begin
        tx_col <= 1'b1;
        idle(1);
        tx_col <= 1'b0;
        idle(1);
      end
      idle(2);
      chk(n_xcol - n0 == (r ? 0 : 1), "excess collision drop");
    end
    apb(1, IDX_CFG4, 32'h0);
    n0 = n_xcol;
    for (int c = 0; c < 16; c++) begin
      if (c == 8) begin
        tx_done <= 1'b1;
        idle(1);
        tx_done <= 1'b0;
      end
      tx_col <= 1'b1;
      idle(1);
      tx_col <= 1'b0;
      idle(1);
    end
    idle(2);
    chk(n_xcol - n0 == 0, "collision count kept across frames");
  endtask : t_xcol
  task automatic t_storm();
    int t0;
    apb(1, IDX_STORM, 32'h102);
    for (int s = 0; s < 2; s++) begin
      apb(1, IDX_PORT, s ? 32'h1 : 32'h3);
      for (int j = 0; j < 2; j++) begin
        f = '0;
        f.bcast = 1'b1;
        st.frame(f, 1);
        do apb(0, IDX_STAT, 0); while (q[15:8] !== 8'h00);
        if (j == 0) t0 = cyc;
      end
      chk(cyc - t0 >= (s ? 1996 : 396) && cyc - t0 <= (s ? 2004 : 404), "interval");
    end
    apb(1, IDX_PORT, 32'h3);
    n0 = n_fab;
    st.frame(f, 1);
    f.bcast = 1'b0;
    f.mcast = 1'b1;
    st.frame(f, 1);
    st.frame(f, 1);
    f.mcast = 1'b0;
    st.frame(f, 1);
    idle(3);
    chk(n_fab - n0 == 3, "storm limit");
    apb(0, IDX_STAT, 0);
    chk(q[15:8] === 8'h03, "storm count");
  endtask : t_storm
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {res_busy, tx_q_nempty, tx_col, tx_done} = '0;
    port_id = 3'h1;
    fab_ready = 1'b1;
    idle(10);
    presetn <= 1'b1;
    idle(1);
    t_regs();
    t_filter();
    t_fifo();
    t_flow();
    t_back();
    t_xcol();
    t_storm();
    wrap_up();
  end
endmodule : switch_port_traffic_control_bench

/* File: tb/tc_chk.sv */
// Assertion checker for the port traffic controller.
`timescale 1ns/1ps
module tc_chk #(
  parameter logic [31:0] CARRIER_CYCLES = 32'd50
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Watched ports.
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [2:0] port_id,
  input wire logic rx_valid,
  input wire tc_pkg::rx_beat_s rx_beat,
  input wire logic rx_ready,
  input wire logic rx_pause,
  input wire logic fab_valid,
  input wire tc_pkg::fab_beat_s fab_beat,
  input wire logic fab_ready,
  input wire logic tx_q_nempty,
  input wire logic tx_col,
  input wire logic crs_preamble,
  input wire logic tx_grant,
  input wire logic skip_backoff,
  input wire logic xcol_drop
);
  import tc_pkg::*;
  logic sop_ff;
  logic [31:0] cnt_ff;
  wire errs = rx_beat.frame_err | rx_beat.fcs_err | rx_beat.align_err | rx_beat.len_err;
  wire bad = errs | rx_beat.pause | (rx_beat.dst_port == port_id);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sop_ff <= 1'b1;
      cnt_ff <= '0;
    end else begin
      if (rx_valid && rx_ready) sop_ff <= rx_beat.last;
      cnt_ff <= (crs_preamble && !tx_col) ? cnt_ff + 32'd1 : '0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_zero_wait: assert property (psel && penable |-> pready)
    else $error("apb access stalled");
  chk_drop_accept: assert property (rx_valid && sop_ff && bad |-> rx_ready)
    else $error("dropped frame stalled");
  chk_pause_pulse: assert property (rx_valid && rx_ready && sop_ff && rx_beat.pause && !errs
    |=> rx_pause)
    else $error("pause frame not consumed");
  chk_carrier_len: assert property (cnt_ff <= CARRIER_CYCLES)
    else $error("carrier held too long");
  chk_gap_short: assert property ($fell(crs_preamble) && !tx_grant
    |-> ##[1:193] (crs_preamble || tx_grant))
    else $error("silent gap too long");
  chk_carrier_excl: assert property (crs_preamble |-> !tx_grant)
    else $error("carrier while transmitting");
  chk_tx_first: assert property (tx_q_nempty && crs_preamble |=> tx_grant)
    else $error("queued frames not served");
  chk_col_carrier: assert property (tx_col && skip_backoff && !tx_grant && !tx_q_nempty
    |=> crs_preamble)
    else $error("no carrier after collision");
  chk_xcol_cause: assert property (xcol_drop |-> $past(tx_col))
    else $error("drop without collision");
  chk_fab_hold: assert property (fab_valid && !fab_ready |=> fab_valid && $stable(fab_beat))
    else $error("fabric beat changed while stalled");
endmodule : tc_chk

bind switch_port_traffic_control tc_chk #(.CARRIER_CYCLES(CARRIER_CYCLES)) u_chk (
  .pclk, .presetn, .psel, .penable, .pready, .port_id, .rx_valid, .rx_beat, .rx_ready,
  .rx_pause, .fab_valid, .fab_beat, .fab_ready, .tx_q_nempty, .tx_col, .crs_preamble,
  .tx_grant, .skip_backoff, .xcol_drop
);

/* File: tb/tc_station.sv */
// Remote station model that sends frames into the port's receive side.
`timescale 1ns/1ps
module tc_station (
  // Clock.
  input wire logic pclk,
  // Receive stream towards the port.
  output logic rx_valid,
  output tc_pkg::rx_beat_s rx_beat,
  input wire logic rx_ready
);
  import tc_pkg::*;
  initial begin
    rx_valid = 1'b0;
    rx_beat = '0;
  end
  // Sends n beats counting up from f.data; a released line shows the inverse.
  task automatic frame(input rx_beat_s f, input int n);
    rx_beat_s b;
    b = f;
    rx_valid <= 1'b1;
    for (int i = 0; i < n; i++) begin
      b.data = f.data + i;
      b.last = (i == n - 1);
      rx_beat <= b;
      do @(posedge pclk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_beat <= ~b;
    @(posedge pclk);
  endtask : frame
endmodule : tc_station
